// ---- include/quad_pot_defines.svh ----
// constants of the quad potentiometer serial command block
`ifndef QUAD_POT_DEFINES_SVH
`define QUAD_POT_DEFINES_SVH
`define WORD_BITS 16
`define OP_MSB 15
`define OP_LSB 12
`define ADDR_MSB 11
`define ADDR_LSB 8
`define DATA_MSB 7
`define CODE_BITS 6
`define TAPS 64
`define CHANNELS 4
`define NV_DEPTH 16
`define CNT_BITS 5
`define CNT_FULL 5'h10
`define NV_RESET 8'h00
`define WIPER_RESET 6'h00
`define CODE_ONE 6'h01
`define CODE_MID 6'h20
`define CODE_FULL 6'h3F
`define USER_FIRST 4'h5
`endif

// ---- include/quad_pot_pkg.sv ----
// types of the quad potentiometer serial command block
package quad_pot_pkg;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_RESTORE = 4'h1,
    OP_STORE = 4'h2,
    OP_USER_WR = 4'h3,
    OP_RESTORE_ALL = 4'h8,
    OP_NV_READ = 4'h9,
    OP_WIPER_READ = 4'hA,
    OP_WIPER_WR = 4'hB,
    OP_SHIFT_UP = 4'hC,
    OP_INC = 4'hE
  } opcode_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_EXEC = 3'b100
  } link_state_t;
  typedef logic [5:0] code_t;
endpackage

// ---- include/tap_if.sv ----
// wiper code to tap switch connection between controller and decoder
`timescale 1ns/1ps
interface tap_if #(
  parameter int CODE_BITS = 6,
  parameter int TAPS = 64
);
  logic [CODE_BITS-1:0] code;
  logic [TAPS-1:0] sel;
  modport ctrl (output code, input sel);
  modport dec (input code, output sel);
endinterface

// ---- src/tap_decoder.sv ----
// registered one-hot tap switch decoder for one wiper
`timescale 1ns/1ps
`include "quad_pot_defines.svh"
module tap_decoder #(
  parameter int TAPS = `TAPS
) (
  input wire logic clk,
  input wire logic rst_b,
  tap_if.dec bus
);
  logic [TAPS-1:0] sel_r;
  logic [TAPS-1:0] sel_nxt;

  // code zero closes the switch at the terminal-B end
  assign sel_nxt = {{(TAPS-1){1'b0}}, 1'b1} << bus.code;
  assign bus.sel = sel_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_r <= {{(TAPS-1){1'b0}}, 1'b1};
    end else begin
      sel_r <= sel_nxt;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  one_switch_a: assert property ($onehot(sel_r))
    else $error("tap switches not one-hot");
  tap_match_a: assert property (##1 sel_r[$past(bus.code)])
    else $error("closed switch does not match code");
endmodule

// ---- src/quad_pot_serial_commands.sv ----
// serial command interpreter for a quad 64-position nonvolatile potentiometer
`timescale 1ns/1ps
`include "quad_pot_defines.svh"
module quad_pot_serial_commands #(
  parameter int NV_DEPTH = `NV_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic sdi,
  input wire logic wp_b,
  input wire logic preset_restore_input_b,
  output logic sdo,
  output logic idle_power,
  output logic [`CHANNELS-1:0][`TAPS-1:0] tap_switch
);
  localparam int CHANNELS = `CHANNELS;

  // one step up, held at full scale
  function automatic quad_pot_pkg::code_t inc_sat(input quad_pot_pkg::code_t c);
    inc_sat = (c == `CODE_FULL) ? c : c + `CODE_ONE;
  endfunction

  // left shift that never wraps: zero goes to one, midscale and up to full
  function automatic quad_pot_pkg::code_t shift_up(input quad_pot_pkg::code_t c);
    if (c == `WIPER_RESET) begin
      shift_up = `CODE_ONE;
    end else if (c >= `CODE_MID) begin
      shift_up = `CODE_FULL;
    end else begin
      shift_up = {c[`CODE_BITS-2:0], 1'b0};
    end
  endfunction

  quad_pot_pkg::link_state_t state_r;
  quad_pot_pkg::link_state_t state_nxt;
  logic sclk_q_r;
  logic cs_q_r;
  logic pr_q_r;
  logic por_r;
  logic [`WORD_BITS-1:0] sr_r;
  logic [`WORD_BITS-1:0] sr_nxt;
  logic [`CNT_BITS-1:0] bit_cnt_r;
  logic [`CNT_BITS-1:0] bit_cnt_nxt;
  logic sdo_r;
  logic sdo_nxt;
  logic idle_r;
  logic idle_nxt;
  quad_pot_pkg::code_t wiper_code_register [CHANNELS];
  logic [7:0] nonvolatile_store [NV_DEPTH];

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic pr_fall;
  logic restore_all;
  logic exec;
  quad_pot_pkg::opcode_t op;
  logic [3:0] addr;
  logic [7:0] data;
  logic is_wiper_addr;
  quad_pot_pkg::code_t addr_wiper;
  logic nv_wr_en;
  logic [7:0] nv_wr_data;
  logic read_prep;
  logic [7:0] read_byte;
  logic word_ok;

  // serial pins are synchronous to clk, so plain edge detection suffices
  assign sclk_rise = sclk & ~sclk_q_r;
  assign sclk_fall = ~sclk & sclk_q_r;
  assign cs_fall = ~cs_b & cs_q_r;
  assign cs_rise = cs_b & ~cs_q_r;
  assign pr_fall = ~preset_restore_input_b & pr_q_r;

  // instruction, address and data fields of the captured word
  assign op = quad_pot_pkg::opcode_t'(sr_r[`OP_MSB:`OP_LSB]);
  assign addr = sr_r[`ADDR_MSB:`ADDR_LSB];
  assign data = sr_r[`DATA_MSB:0];
  assign exec = (state_r == quad_pot_pkg::ST_EXEC);
  assign word_ok = (bit_cnt_r == `CNT_FULL);
  assign is_wiper_addr = (addr < 4'(CHANNELS));
  assign addr_wiper = wiper_code_register[addr[1:0]];

  // power-on and the preset strobe win over any wiper command in the same cycle
  assign restore_all = por_r | pr_fall
    | (exec & (op == quad_pot_pkg::OP_RESTORE_ALL));

  assign nv_wr_en = exec & wp_b
    & (((op == quad_pot_pkg::OP_STORE) & is_wiper_addr)
    | (op == quad_pot_pkg::OP_USER_WR));
  assign nv_wr_data = (op == quad_pot_pkg::OP_STORE) ?
    {2'b00, addr_wiper} : data;

  assign read_prep = exec
    & ((op == quad_pot_pkg::OP_NV_READ) | (op == quad_pot_pkg::OP_WIPER_READ));
  assign read_byte = (op == quad_pot_pkg::OP_NV_READ) ?
    nonvolatile_store[addr] : {2'b00, addr_wiper};

  // the command byte stays in the upper half so the next frame echoes it
  assign sr_nxt = read_prep ? {sr_r[`OP_MSB:`ADDR_LSB], read_byte}
    : (sclk_rise & ~cs_b) ? {sr_r[`WORD_BITS-2:0], sdi}
    : sr_r;

  // extra clocks beyond sixteen keep only the last sixteen bits
  assign bit_cnt_nxt = cs_fall ? '0
    : (sclk_rise & ~cs_b & ~word_ok) ? bit_cnt_r + `CNT_BITS'(1)
    : bit_cnt_r;

  // next bit goes out after each falling sclk, so the host samples on rise
  assign sdo_nxt = (cs_b | sclk_fall) ? sr_r[`WORD_BITS-1] : sdo_r;

  // restore and read commands raise power until a no-op; power-on and preset do not
  assign idle_nxt = (exec & (op == quad_pot_pkg::OP_NOP)) ? 1'b1
    : (read_prep | (exec & ((op == quad_pot_pkg::OP_RESTORE)
    | (op == quad_pot_pkg::OP_RESTORE_ALL)))) ? 1'b0
    : idle_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      quad_pot_pkg::ST_IDLE: begin
        if (cs_fall) begin
          state_nxt = quad_pot_pkg::ST_SHIFT;
        end
      end
      quad_pot_pkg::ST_SHIFT: begin
        if (cs_rise) begin
          // a short frame is dropped rather than executed
          state_nxt = word_ok ? quad_pot_pkg::ST_EXEC : quad_pot_pkg::ST_IDLE;
        end
      end
      quad_pot_pkg::ST_EXEC: begin
        state_nxt = quad_pot_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = quad_pot_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= quad_pot_pkg::ST_IDLE;
      sclk_q_r <= 1'b0;
      cs_q_r <= 1'b1;
      pr_q_r <= 1'b1;
      por_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      sclk_q_r <= sclk;
      cs_q_r <= cs_b;
      pr_q_r <= preset_restore_input_b;
      por_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sr_r <= '0;
      bit_cnt_r <= '0;
      sdo_r <= 1'b0;
      idle_r <= 1'b1;
    end else begin
      sr_r <= sr_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      sdo_r <= sdo_nxt;
      idle_r <= idle_nxt;
    end
  end

  // contents are modelled as flops cleared at reset; a real array keeps them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int k = 0; k < NV_DEPTH; k++) begin
        nonvolatile_store[k] <= `NV_RESET;
      end
    end else if (nv_wr_en) begin
      nonvolatile_store[addr] <= nv_wr_data;
    end
  end

  for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
    logic hit;
    quad_pot_pkg::code_t wiper_nxt;
    tap_if #(.CODE_BITS(`CODE_BITS), .TAPS(`TAPS)) bus ();

    assign hit = exec & (addr == 4'(i));
    assign wiper_nxt =
      (restore_all | (hit & (op == quad_pot_pkg::OP_RESTORE))) ?
        nonvolatile_store[i][`CODE_BITS-1:0]
      : (hit & (op == quad_pot_pkg::OP_WIPER_WR)) ? data[`CODE_BITS-1:0]
      : (hit & (op == quad_pot_pkg::OP_INC)) ? inc_sat(wiper_code_register[i])
      : (hit & (op == quad_pot_pkg::OP_SHIFT_UP)) ?
        shift_up(wiper_code_register[i])
      : wiper_code_register[i];

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        wiper_code_register[i] <= `WIPER_RESET;
      end else begin
        wiper_code_register[i] <= wiper_nxt;
      end
    end

    assign bus.code = wiper_code_register[i];
    assign tap_switch[i] = bus.sel;

    tap_decoder #(.TAPS(`TAPS)) u_dec (
      .clk(clk),
      .rst_b(rst_b),
      .bus(bus)
    );
  end

  assign sdo = sdo_r;
  assign idle_power = idle_r;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  wiper_write_a: assert property (
    exec && op == quad_pot_pkg::OP_WIPER_WR && addr == 4'h0 && !restore_all
    |=> wiper_code_register[0] == $past(data[`CODE_BITS-1:0]))
    else $error("wiper write did not load the data byte");

  inc_step_a: assert property (
    exec && op == quad_pot_pkg::OP_INC && addr == 4'h0 && !restore_all
    && wiper_code_register[0] != `CODE_FULL
    |=> wiper_code_register[0] == $past(wiper_code_register[0]) + `CODE_ONE)
    else $error("increment did not add one");

  store_copy_a: assert property (
    exec && op == quad_pot_pkg::OP_STORE && addr == 4'h0 && wp_b
    |=> nonvolatile_store[0] == {2'b00, $past(wiper_code_register[0])})
    else $error("store did not copy the wiper");

  restore_low_a: assert property (
    exec && op == quad_pot_pkg::OP_RESTORE && addr == 4'h0
    |=> wiper_code_register[0] == $past(nonvolatile_store[0][`CODE_BITS-1:0]))
    else $error("restore did not load the saved low six bits");

  preset_reload_a: assert property (
    pr_q_r && !preset_restore_input_b
    |=> wiper_code_register[1] == $past(nonvolatile_store[1][`CODE_BITS-1:0]))
    else $error("preset strobe did not reload the wiper");

  shift_double_a: assert property (
    exec && op == quad_pot_pkg::OP_SHIFT_UP && addr == 4'h0 && !restore_all
    && wiper_code_register[0] != `WIPER_RESET && wiper_code_register[0] < `CODE_MID
    |=> wiper_code_register[0] == 6'($past(wiper_code_register[0]) << 1))
    else $error("left shift did not double the code");

  shift_sat_a: assert property (
    exec && op == quad_pot_pkg::OP_SHIFT_UP && addr == 4'h0 && !restore_all
    && wiper_code_register[0] >= `CODE_MID
    |=> wiper_code_register[0] == `CODE_FULL)
    else $error("left shift above midscale did not go to full scale");

  user_write_a: assert property (
    exec && op == quad_pot_pkg::OP_USER_WR && addr == `USER_FIRST && wp_b
    |=> nonvolatile_store[5] == $past(data))
    else $error("user byte not stored");

  nv_readback_a: assert property (
    exec && op == quad_pot_pkg::OP_NV_READ && addr == `USER_FIRST
    |=> sr_r == {$past(sr_r[`OP_MSB:`ADDR_LSB]), $past(nonvolatile_store[5])})
    else $error("user byte readback word wrong");

  wiper_readback_a: assert property (
    exec && op == quad_pot_pkg::OP_WIPER_READ && addr == 4'h0
    |=> sr_r == {$past(sr_r[`OP_MSB:`ADDR_LSB]), 2'b00, $past(wiper_code_register[0])})
    else $error("wiper readback word wrong");

  sdo_hold_a: assert property (
    !cs_b && !sclk_fall |=> $stable(sdo_r))
    else $error("serial output moved away from a falling sclk");

  exec_on_cs_a: assert property (
    state_r == quad_pot_pkg::ST_EXEC |-> $past(cs_rise) && $past(bit_cnt_r) == `CNT_FULL)
    else $error("command executed without a full frame end");

  shift_in_a: assert property (
    sclk_rise && !cs_b && !read_prep |=> sr_r[0] == $past(sdi) && sr_r[15:1] == $past(sr_r[14:0]))
    else $error("serial word not shifted msb first");

  cover_inc_c: cover property (exec && op == quad_pot_pkg::OP_INC);
  cover_sat_c: cover property (exec && op == quad_pot_pkg::OP_SHIFT_UP
    && wiper_code_register[0] == `CODE_MID);
  cover_read_c: cover property (exec && op == quad_pot_pkg::OP_NV_READ
    ##[1:1000] exec && op == quad_pot_pkg::OP_NOP);
endmodule

// ---- verification/spi_host_model.sv ----
// host side model that frames 16-bit words on the serial link
`timescale 1ns/1ps
module spi_host_model (
  input wire logic clk,
  input wire logic sdo,
  output logic sclk,
  output logic cs_b,
  output logic sdi
);
  // serial clock stands still low between frames
  initial begin
    sclk = 1'h0;
    cs_b = 1'h1;
    sdi = 1'h0;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one frame; rx gathers what the device shifts out while the word goes in
  task automatic xfer(input logic [15:0] word, output logic [15:0] rx);
    xfer_n(word, 16, rx);
  endtask

  // frame of the top nbits of word; fewer than sixteen makes a cut frame
  task automatic xfer_n(input logic [15:0] word, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    cs_b = 1'h0;
    for (int i = 15; i >= 16 - nbits; i--) begin
      sdi = word[i];
      gap(2);
      rx[i] = sdo;
      sclk = 1'h1;
      gap(2);
      sclk = 1'h0;
    end
    gap(2);
    cs_b = 1'h1;
    // released line has no pull, so show the inverse rather than a stale level
    sdi = ~word[16 - nbits];
    gap(4);
  endtask
endmodule

// ---- verification/test_quad_pot_serial_commands.sv ----
// self-checking bench for the serial command interpreter
`timescale 1ns/1ps
`include "quad_pot_defines.svh"
module test_quad_pot_serial_commands;
  logic clk;
  logic rst_b;
  logic wp_b;
  logic preset_restore_input_b;
  logic sclk;
  logic cs_b;
  logic sdi;
  logic sdo;
  logic idle_power;
  logic [`CHANNELS-1:0][`TAPS-1:0] tap_switch;
  logic [15:0] rx;
  int n_mismatch = 0;
  int n_compared = 0;

  quad_pot_serial_commands quad_pot_serial_commands_inst (
    .clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .sdi(sdi), .wp_b(wp_b),
    .preset_restore_input_b(preset_restore_input_b), .sdo(sdo),
    .idle_power(idle_power), .tap_switch(tap_switch)
  );

  spi_host_model spi_host_model_inst (
    .clk(clk), .sdo(sdo), .sclk(sclk), .cs_b(cs_b), .sdi(sdi)
  );

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [63:0] tap(input logic [5:0] code);
    return 64'h1 << code;
  endfunction

  // effect lands two edges after the frame closes, taps one later; four is margin
  task automatic cmd(input logic [15:0] w);
    spi_host_model_inst.xfer(w, rx);
    repeat (4) @(negedge clk);
  endtask

  task automatic test_reset;
    for (int ch = 0; ch < `CHANNELS; ch++) chk(tap_switch[ch], tap(6'h00));
    chk(idle_power, 1'h1);
    $display("test_reset done");
  endtask

  task automatic test_write_inc;
    cmd(16'hB010);
    chk(tap_switch[0], tap(6'h10));
    chk(tap_switch[1], tap(6'h00));
    cmd(16'hE0C3);
    chk(rx, 16'hB010);
    chk(tap_switch[0], tap(6'h11));
    cmd(16'hE000);
    chk(tap_switch[0], tap(6'h12));
    $display("test_write_inc done");
  endtask

  task automatic test_store_restore;
    cmd(16'h2000);
    cmd(16'hB005);
    cmd(16'h1000);
    chk(tap_switch[0], tap(6'h12));
    chk(idle_power, 1'h0);
    cmd(16'h0000);
    chk(idle_power, 1'h1);
    cmd(16'hB001);
    preset_restore_input_b = 1'h0;
    repeat (2) @(negedge clk);
    preset_restore_input_b = 1'h1;
    repeat (4) @(negedge clk);
    chk(tap_switch[0], tap(6'h12));
    cmd(16'h30C5);
    cmd(16'h1000);
    chk(tap_switch[0], tap(6'h05));
    cmd(16'h0000);
    $display("test_store_restore done");
  endtask

  task automatic test_protect;
    wp_b = 1'h0;
    cmd(16'hB030);
    cmd(16'h2000);
    cmd(16'h1000);
    chk(tap_switch[0], tap(6'h05));
    cmd(16'h0000);
    wp_b = 1'h1;
    $display("test_protect done");
  endtask

  task automatic test_shift;
    cmd(16'hB000);
    cmd(16'hC000);
    chk(tap_switch[0], tap(6'h01));
    cmd(16'hB007);
    cmd(16'hC000);
    chk(tap_switch[0], tap(6'h0E));
    cmd(16'hB020);
    cmd(16'hC0FF);
    chk(rx, 16'hB020);
    chk(tap_switch[0], tap(6'h3F));
    cmd(16'hA000);
    cmd(16'h0000);
    chk(rx, 16'hA03F);
    $display("test_shift done");
  endtask

  task automatic test_user;
    cmd(16'h35AA);
    cmd(16'h3655);
    chk(rx, 16'h35AA);
    cmd(16'h9500);
    cmd(16'h0000);
    chk(rx, 16'h95AA);
    cmd(16'h9600);
    cmd(16'h0000);
    chk(rx, 16'h9655);
    chk(idle_power, 1'h1);
    $display("test_user done");
  endtask

  // a cut frame must be dropped; the next full frame still executes
  task automatic test_short;
    spi_host_model_inst.xfer_n(16'hB010, 15, rx);
    repeat (4) @(negedge clk);
    chk(tap_switch[0], tap(6'h3F));
    cmd(16'hB010);
    chk(rx, 16'h5808);
    chk(tap_switch[0], tap(6'h10));
    $display("test_short done");
  endtask

  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    rst_b = 1'h0;
    wp_b = 1'h1;
    preset_restore_input_b = 1'h1;
    repeat (16) @(negedge clk);
    rst_b = 1'h1;
    repeat (4) @(negedge clk);
    test_reset;
    test_write_inc;
    test_store_restore;
    test_protect;
    test_shift;
    test_user;
    test_short;
    final_report;
  end

  // 31 frames of some 80 cycles each; the limit leaves wide margin
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("watchdog expired");
    final_report;
  end
endmodule
